//--- tfx_defs.svh
`ifndef TFX_DEFS_SVH
`define TFX_DEFS_SVH
// ****************************************
// instruction cycle timing
// ****************************************
// oscillator periods in one instruction cycle
`define TFX_OSC_PER_ICYC 4
// ****************************************
// reset values
// ****************************************
`define TFX_PC_RESET 16'h0000
`define TFX_SP_RESET 16'h0000
`define TFX_PS_RESET 16'h0000
// ****************************************
// program status word layout
// ****************************************
// bank select field
`define TFX_PS_BANK_HI 15
`define TFX_PS_BANK_LO 11
// condition flags in the low byte
`define TFX_CC_N 3
`define TFX_CC_Z 2
`define TFX_CC_V 1
`define TFX_CC_C 0
// ****************************************
// opcodes that need special handling
// ****************************************
`define TFX_OP_SWAP 8'h10
`define TFX_OP_XCH_LOW 8'h42
`define TFX_OP_XCHW_T 8'h43
`define TFX_OP_PS_TO_A 8'h70
`define TFX_OP_A_TO_PS 8'h71
`endif

//--- tfx_pkg.sv
package tfx_pkg;
  // ****************************************
  // sequencer and decode types
  // ****************************************
  // one state per instruction cycle kind
  typedef enum logic [2:0] {S_FETCH, S_OPND, S_ACC, S_PAD, S_OTHER} tfx_state_t;
  // where the data operand lives
  typedef enum logic [2:0] {EA_NONE, EA_DIR, EA_IX, EA_EXT, EA_EP, EA_A, EA_RI} tfx_ea_t;
  // what the instruction does with it
  typedef enum logic [2:0] {K_LD, K_ST, K_STIMM, K_STT, K_BIT, K_REG, K_OTHER} tfx_kind_t;
  // decoded opcode
  typedef struct packed {
    logic [4:0] cyc;
    logic [1:0] nbytes;
    tfx_ea_t ea;
    tfx_kind_t kind;
    logic word;
  } tfx_dec_t;
  // ****************************************
  // port carriers
  // ****************************************
  // memory request for one instruction cycle
  typedef struct packed {
    logic rd;
    logic wr;
    logic fetch;
    logic [15:0] addr;
    logic [7:0] wdata;
  } tfx_mem_req_t;
  // hand-off to the other instruction groups
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [2:0] vct;
    logic [15:0] pc;
  } tfx_other_req_t;
  // return from the other instruction groups
  typedef struct packed {
    logic done;
    logic [15:0] next_pc;
  } tfx_other_ret_t;
  // architectural state view
  typedef struct packed {
    logic [15:0] acc;
    logic [15:0] tmp;
    logic [15:0] ix;
    logic [15:0] ep;
    logic [15:0] sp;
    logic [15:0] pc;
    logic [15:0] ps;
  } tfx_arch_t;
endpackage : tfx_pkg

//--- tfx_icyc_timer.sv
`timescale 1ns/1ns
`include "tfx_defs.svh"
module tfx_icyc_timer (
  input wire logic clock,
  input wire logic arst_n,
  output logic tick
);
  // ****************************************
  // oscillator period counter
  // ****************************************
  localparam logic [1:0] LAST = 2'(`TFX_OSC_PER_ICYC - 1); // last period of a cycle
  logic [1:0] cnt_q; // period within instruction cycle
  logic [1:0] cnt_d;

  // wrap after four periods
  always_comb begin
    cnt_d = (cnt_q == LAST) ? 2'h0 : cnt_q + 2'h1;
  end

  // count register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= 2'h0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // high in the last period of each instruction cycle
  assign tick = (cnt_q == LAST);
endmodule : tfx_icyc_timer

//--- tfx_gpr_bank.sv
`timescale 1ns/1ns
module tfx_gpr_bank (
  input wire logic clock,
  input wire logic [4:0] bank,
  input wire logic [2:0] idx,
  input wire logic we,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  // ****************************************
  // banked general registers
  // ****************************************
  logic [7:0] mem_q [0:255]; // 32 banks of eight bytes

  // bank and index form the row
  function automatic logic [7:0] row(input logic [4:0] b, input logic [2:0] i);
    row = {b, i};
  endfunction : row

  // write port
  always_ff @(posedge clock) begin
    if (we) begin
      mem_q[row(bank, idx)] <= wdata;
    end
  end

  // read port, combinational
  assign rdata = mem_q[row(bank, idx)];
endmodule : tfx_gpr_bank

//--- tfx_xfer_core.sv
`timescale 1ns/1ns
`include "tfx_defs.svh"
// How it works
// - direct and offset bytes, extended address word
// - vector index is opcode low three bits
// - bit operand is direct byte plus bit
// - eight general bytes per bank
// - five-bit bank select picks the bank
// - flags byte lives in status word
// - sixteen-bit pointers moved by word transfers
// - accumulator works as byte or word
// - temporary accumulator works as byte or word
// - byte load copies only low byte over
// - word results write accumulator upper byte
// - low three opcode bits pick register
// - operand bytes follow assembler order
// - word store writes high then low
// - indirect word store of temporary, high first
// - immediate byte load sets negative, zero
// - byte exchange swaps only low bytes
// - bit set and clear, read-modify-write
// - swap exchanges accumulator bytes
// - only marked instructions change flags
// - pad to the cycle count, then fetch
// - instruction cycle is four clock periods
module tfx_xfer_core (
  input wire logic clock,
  input wire logic arst_n,
  output tfx_pkg::tfx_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  output tfx_pkg::tfx_other_req_t other_req,
  input wire tfx_pkg::tfx_other_ret_t other_ret,
  output tfx_pkg::tfx_arch_t arch
);
  // ****************************************
  // helper functions
  // ****************************************
  // build one decode entry
  function automatic tfx_pkg::tfx_dec_t mk(input logic [4:0] c, input logic [1:0] n,
                                           input tfx_pkg::tfx_ea_t e,
                                           input tfx_pkg::tfx_kind_t k, input logic w);
    mk = '{cyc: c, nbytes: n, ea: e, kind: k, word: w};
  endfunction : mk

  // opcode to cycles, bytes, operand and action
  function automatic tfx_pkg::tfx_dec_t tfx_decode(input logic [7:0] o);
    tfx_pkg::tfx_dec_t d;
    d = mk(5'h1, 2'h1, tfx_pkg::EA_NONE, tfx_pkg::K_OTHER, 1'b0);
    unique casez (o)
      8'h45: d = mk(5'h3, 2'h2, tfx_pkg::EA_DIR, tfx_pkg::K_ST, 1'b0);
      8'h46: d = mk(5'h4, 2'h2, tfx_pkg::EA_IX, tfx_pkg::K_ST, 1'b0);
      8'h61: d = mk(5'h4, 2'h3, tfx_pkg::EA_EXT, tfx_pkg::K_ST, 1'b0);
      8'h47: d = mk(5'h3, 2'h1, tfx_pkg::EA_EP, tfx_pkg::K_ST, 1'b0);
      8'b0100_1???: d = mk(5'h3, 2'h1, tfx_pkg::EA_RI, tfx_pkg::K_ST, 1'b0);
      8'h04: d = mk(5'h2, 2'h2, tfx_pkg::EA_NONE, tfx_pkg::K_LD, 1'b0);
      8'h05: d = mk(5'h3, 2'h2, tfx_pkg::EA_DIR, tfx_pkg::K_LD, 1'b0);
      8'h06: d = mk(5'h4, 2'h2, tfx_pkg::EA_IX, tfx_pkg::K_LD, 1'b0);
      8'h60: d = mk(5'h4, 2'h3, tfx_pkg::EA_EXT, tfx_pkg::K_LD, 1'b0);
      8'h92: d = mk(5'h3, 2'h1, tfx_pkg::EA_A, tfx_pkg::K_LD, 1'b0);
      8'h07: d = mk(5'h3, 2'h1, tfx_pkg::EA_EP, tfx_pkg::K_LD, 1'b0);
      8'b0000_1???: d = mk(5'h3, 2'h1, tfx_pkg::EA_RI, tfx_pkg::K_LD, 1'b0);
      8'h85: d = mk(5'h4, 2'h3, tfx_pkg::EA_DIR, tfx_pkg::K_STIMM, 1'b0);
      8'h86: d = mk(5'h5, 2'h3, tfx_pkg::EA_IX, tfx_pkg::K_STIMM, 1'b0);
      8'h87: d = mk(5'h4, 2'h2, tfx_pkg::EA_EP, tfx_pkg::K_STIMM, 1'b0);
      8'b1000_1???: d = mk(5'h4, 2'h2, tfx_pkg::EA_RI, tfx_pkg::K_STIMM, 1'b0);
      8'hd5: d = mk(5'h4, 2'h2, tfx_pkg::EA_DIR, tfx_pkg::K_ST, 1'b1);
      8'hd6: d = mk(5'h5, 2'h2, tfx_pkg::EA_IX, tfx_pkg::K_ST, 1'b1);
      8'hd4: d = mk(5'h5, 2'h3, tfx_pkg::EA_EXT, tfx_pkg::K_ST, 1'b1);
      8'hd7: d = mk(5'h4, 2'h1, tfx_pkg::EA_EP, tfx_pkg::K_ST, 1'b1);
      8'he4: d = mk(5'h3, 2'h3, tfx_pkg::EA_NONE, tfx_pkg::K_LD, 1'b1);
      8'hc5: d = mk(5'h4, 2'h2, tfx_pkg::EA_DIR, tfx_pkg::K_LD, 1'b1);
      8'hc6: d = mk(5'h5, 2'h2, tfx_pkg::EA_IX, tfx_pkg::K_LD, 1'b1);
      8'hc4: d = mk(5'h5, 2'h3, tfx_pkg::EA_EXT, tfx_pkg::K_LD, 1'b1);
      8'h93: d = mk(5'h4, 2'h1, tfx_pkg::EA_A, tfx_pkg::K_LD, 1'b1);
      8'hc7: d = mk(5'h4, 2'h1, tfx_pkg::EA_EP, tfx_pkg::K_LD, 1'b1);
      8'he1, 8'he2, 8'he3, 8'hf0, 8'hf1, 8'hf2, 8'hf3, 8'h70, 8'h71, 8'h10, 8'h42:
        d = mk(5'h2, 2'h1, tfx_pkg::EA_NONE, tfx_pkg::K_REG, 1'b1);
      8'he5, 8'he6, 8'he7: d = mk(5'h3, 2'h3, tfx_pkg::EA_NONE, tfx_pkg::K_REG, 1'b1);
      8'hf5, 8'hf6, 8'hf7, 8'h43: d = mk(5'h3, 2'h1, tfx_pkg::EA_NONE, tfx_pkg::K_REG, 1'b1);
      8'h82: d = mk(5'h3, 2'h1, tfx_pkg::EA_A, tfx_pkg::K_STT, 1'b0);
      8'h83: d = mk(5'h4, 2'h1, tfx_pkg::EA_A, tfx_pkg::K_STT, 1'b1);
      8'b1010_????: d = mk(5'h4, 2'h2, tfx_pkg::EA_DIR, tfx_pkg::K_BIT, 1'b0);
      default: ;
    endcase
    tfx_decode = d;
  endfunction : tfx_decode

  // number of data accesses of an instruction
  function automatic logic [1:0] tfx_nacc(input tfx_pkg::tfx_dec_t d);
    if (d.ea == tfx_pkg::EA_NONE || d.ea == tfx_pkg::EA_RI) begin
      tfx_nacc = 2'h0;
    end else if (d.kind == tfx_pkg::K_BIT || d.word) begin
      tfx_nacc = 2'h2;
    end else begin
      tfx_nacc = 2'h1;
    end
  endfunction : tfx_nacc

  // effective address of the data operand
  function automatic logic [15:0] tfx_ea(input tfx_pkg::tfx_ea_t m, input logic [15:0] o,
                                         input logic [15:0] ixv, input logic [15:0] epv,
                                         input logic [15:0] av);
    unique case (m)
      tfx_pkg::EA_DIR: tfx_ea = {8'h00, o[15:8]};
      tfx_pkg::EA_IX: tfx_ea = ixv + {{8{o[15]}}, o[15:8]};
      tfx_pkg::EA_EXT: tfx_ea = o;
      tfx_pkg::EA_EP: tfx_ea = epv;
      tfx_pkg::EA_A: tfx_ea = av;
      default: tfx_ea = 16'h0000;
    endcase
  endfunction : tfx_ea

  // one memory request
  function automatic tfx_pkg::tfx_mem_req_t tfx_mreq(input logic r, input logic w,
                                                    input logic f, input logic [15:0] a,
                                                    input logic [7:0] wd);
    tfx_mreq = '{rd: r, wr: w, fetch: f, addr: a, wdata: wd};
  endfunction : tfx_mreq

  // ****************************************
  // state
  // ****************************************
  tfx_pkg::tfx_state_t st_q, st_d; // sequencer state
  logic [7:0] op_q, op_d; // current opcode
  logic [15:0] opnd_q, opnd_d; // operand bytes, first in upper half
  logic [1:0] nop_q, nop_d; // operand bytes fetched
  logic [1:0] k_q, k_d; // data access index
  logic [15:0] ea_q, ea_d; // effective address
  logic [15:0] dat_q, dat_d; // data read, first byte in upper half
  logic [4:0] icyc_q, icyc_d; // instruction cycles completed
  logic [15:0] acc_q, acc_d, tmp_q, tmp_d; // accumulators
  logic [15:0] ix_q, ix_d, ep_q, ep_d, sp_q, sp_d, pc_q, pc_d, ps_q, ps_d; // pointers
  tfx_pkg::tfx_mem_req_t mem_q, mem_d; // memory request register
  tfx_pkg::tfx_other_req_t oth_q, oth_d; // hand-off register
  // combinational helpers
  logic tick; // last period of an instruction cycle
  logic [7:0] opc; // opcode being worked on
  tfx_pkg::tfx_dec_t dec; // its decode
  logic [1:0] nacc; // its data accesses
  logic [4:0] done_n; // cycles done at this tick
  logic [7:0] imm8; // last operand byte
  logic [15:0] src; // load source value
  logic [15:0] ptr; // pointer selected by opcode
  logic ops_ready, wb, finish, issue, pw_en; // step flags
  logic [15:0] pw_val; // pointer write value
  logic gpr_we; // general register write
  logic [7:0] gpr_wdata, gpr_rdata; // general register data
  logic [7:0] bmask; // single bit mask

  // ****************************************
  // submodules
  // ****************************************
  tfx_icyc_timer u_timer (
    .clock(clock),
    .arst_n(arst_n),
    .tick(tick)
  );

  tfx_gpr_bank u_gpr (
    .clock(clock),
    .bank(ps_q[`TFX_PS_BANK_HI:`TFX_PS_BANK_LO]),
    .idx(opc[2:0]),
    .we(gpr_we),
    .wdata(gpr_wdata),
    .rdata(gpr_rdata)
  );

  // ****************************************
  // sequencer next state
  // ****************************************
  always_comb begin
    opc = (st_q == tfx_pkg::S_FETCH) ? mem_rdata : op_q;
    dec = tfx_decode(opc);
    nacc = tfx_nacc(dec);
    done_n = (st_q == tfx_pkg::S_FETCH) ? 5'h1 : icyc_q + 5'h1;
    bmask = 8'h01 << opc[2:0];
    st_d = st_q;
    op_d = op_q;
    opnd_d = opnd_q;
    nop_d = nop_q;
    k_d = k_q;
    ea_d = ea_q;
    dat_d = dat_q;
    icyc_d = icyc_q;
    acc_d = acc_q;
    tmp_d = tmp_q;
    ix_d = ix_q;
    ep_d = ep_q;
    sp_d = sp_q;
    pc_d = pc_q;
    ps_d = ps_q;
    mem_d = mem_q;
    oth_d = oth_q;
    gpr_we = 1'b0;
    gpr_wdata = acc_q[7:0];
    ops_ready = 1'b0;
    wb = 1'b0;
    finish = 1'b0;
    issue = 1'b0;
    pw_en = 1'b0;
    pw_val = acc_q;
    src = dat_q;
    imm8 = 8'h00;
    ptr = pc_q;
    if (tick) begin
      icyc_d = done_n;
      unique case (st_q)
        // opcode byte arrives
        tfx_pkg::S_FETCH: begin
          op_d = mem_rdata;
          pc_d = pc_q + 16'h0001;
          nop_d = 2'h0;
          if (dec.kind == tfx_pkg::K_OTHER) begin
            // vector index rides along for the call logic
            oth_d = '{valid: 1'b1, opcode: mem_rdata, vct: mem_rdata[2:0], pc: pc_d};
            mem_d = tfx_mreq(1'b0, 1'b0, 1'b0, pc_d, 8'h00);
            st_d = tfx_pkg::S_OTHER;
          end else if (dec.nbytes == 2'h1) begin
            ops_ready = 1'b1;
          end else begin
            st_d = tfx_pkg::S_OPND;
            mem_d = tfx_mreq(1'b1, 1'b0, 1'b0, pc_d, 8'h00);
          end
        end
        // operand bytes in program order
        tfx_pkg::S_OPND: begin
          if (nop_q == 2'h0) begin
            opnd_d[15:8] = mem_rdata;
          end else begin
            opnd_d[7:0] = mem_rdata;
          end
          nop_d = nop_q + 2'h1;
          pc_d = pc_q + 16'h0001;
          if (nop_q + 2'h2 == dec.nbytes) begin
            ops_ready = 1'b1;
          end else begin
            mem_d = tfx_mreq(1'b1, 1'b0, 1'b0, pc_d, 8'h00);
          end
        end
        // data access ends
        tfx_pkg::S_ACC: begin
          if (mem_q.rd) begin
            dat_d = {dat_q[7:0], mem_rdata};
          end
          k_d = k_q + 2'h1;
          if (k_d == nacc) begin
            wb = 1'b1;
            finish = 1'b1;
          end else begin
            issue = 1'b1;
          end
        end
        // idle cycle to reach the count
        tfx_pkg::S_PAD: finish = 1'b1;
        // outside logic runs the instruction
        tfx_pkg::S_OTHER: begin
          if (other_ret.done) begin
            oth_d.valid = 1'b0;
            pc_d = other_ret.next_pc;
            st_d = tfx_pkg::S_FETCH;
            mem_d = tfx_mreq(1'b1, 1'b0, 1'b1, pc_d, 8'h00);
          end
        end
        default: ;
      endcase
      imm8 = (dec.nbytes == 2'h3) ? opnd_d[7:0] : opnd_d[15:8];
      // operands complete: address and first access
      if (ops_ready) begin
        ea_d = tfx_ea(dec.ea, opnd_d, ix_q, ep_q, acc_q);
        if (nacc == 2'h0) begin
          wb = 1'b1;
          finish = 1'b1;
        end else begin
          st_d = tfx_pkg::S_ACC;
          k_d = 2'h0;
          issue = 1'b1;
        end
      end
      // data access for the next instruction cycle
      if (issue) begin
        unique case (dec.kind)
          tfx_pkg::K_LD: mem_d = tfx_mreq(1'b1, 1'b0, 1'b0, ea_d + {14'h0, k_d}, 8'h00);
          tfx_pkg::K_ST: mem_d = tfx_mreq(1'b0, 1'b1, 1'b0, ea_d + {14'h0, k_d},
                                  (dec.word && k_d == 2'h0) ? acc_q[15:8] : acc_q[7:0]);
          tfx_pkg::K_STT: mem_d = tfx_mreq(1'b0, 1'b1, 1'b0, ea_d + {14'h0, k_d},
                                  (dec.word && k_d == 2'h0) ? tmp_q[15:8] : tmp_q[7:0]);
          tfx_pkg::K_STIMM: mem_d = tfx_mreq(1'b0, 1'b1, 1'b0, ea_d, imm8);
          tfx_pkg::K_BIT: begin
            // read the byte, then write it back with one bit changed
            if (k_d == 2'h0) begin
              mem_d = tfx_mreq(1'b1, 1'b0, 1'b0, ea_d, 8'h00);
            end else begin
              mem_d = tfx_mreq(1'b0, 1'b1, 1'b0, ea_d,
                               opc[3] ? (dat_d[7:0] | bmask) : (dat_d[7:0] & ~bmask));
            end
          end
          default: ;
        endcase
      end
      // register results
      if (wb) begin
        unique case (dec.kind)
          tfx_pkg::K_LD: begin
            if (dec.ea == tfx_pkg::EA_NONE) begin
              src = dec.word ? opnd_d : {8'h00, imm8};
            end else if (dec.ea == tfx_pkg::EA_RI) begin
              src = {8'h00, gpr_rdata};
            end else begin
              src = dat_d;
            end
            if (dec.word) begin
              tmp_d = acc_q;
              acc_d = src;
              ps_d[`TFX_CC_N] = src[15];
              ps_d[`TFX_CC_Z] = (src == 16'h0000);
            end else begin
              tmp_d[7:0] = acc_q[7:0];
              acc_d[7:0] = src[7:0];
              ps_d[`TFX_CC_N] = src[7];
              ps_d[`TFX_CC_Z] = (src[7:0] == 8'h00);
            end
          end
          tfx_pkg::K_ST, tfx_pkg::K_STIMM: begin
            if (dec.ea == tfx_pkg::EA_RI) begin
              gpr_we = 1'b1;
              gpr_wdata = (dec.kind == tfx_pkg::K_ST) ? acc_q[7:0] : imm8;
            end
          end
          tfx_pkg::K_REG: begin
            // pointer picked by low opcode bits, 0 is the counter
            unique case (opc[1:0])
              2'h1: ptr = sp_q;
              2'h2: ptr = ix_q;
              2'h3: ptr = ep_q;
              default: ptr = pc_d;
            endcase
            unique casez (opc)
              8'b1110_00??: pw_en = 1'b1;
              8'b1110_01??: begin
                pw_en = 1'b1;
                pw_val = opnd_d;
              end
              8'b1111_00??: acc_d = ptr;
              8'b1111_01??: begin
                acc_d = ptr;
                pw_en = 1'b1;
              end
              `TFX_OP_PS_TO_A: acc_d = ps_q;
              `TFX_OP_A_TO_PS: ps_d = acc_q;
              `TFX_OP_SWAP: acc_d = {acc_q[7:0], acc_q[15:8]};
              `TFX_OP_XCH_LOW: begin
                acc_d[7:0] = tmp_q[7:0];
                tmp_d[7:0] = acc_q[7:0];
              end
              `TFX_OP_XCHW_T: begin
                acc_d = tmp_q;
                tmp_d = acc_q;
              end
              default: ;
            endcase
            if (pw_en) begin
              unique case (opc[1:0])
                2'h1: sp_d = pw_val;
                2'h2: ix_d = pw_val;
                2'h3: ep_d = pw_val;
                default: ;
              endcase
            end
          end
          default: ;
        endcase
      end
      // end of work: next opcode or idle padding
      if (finish) begin
        if (done_n >= dec.cyc) begin
          st_d = tfx_pkg::S_FETCH;
          mem_d = tfx_mreq(1'b1, 1'b0, 1'b1, pc_d, 8'h00);
        end else begin
          st_d = tfx_pkg::S_PAD;
          mem_d = tfx_mreq(1'b0, 1'b0, 1'b0, pc_d, 8'h00);
        end
      end
    end
  end

  // ****************************************
  // state registers
  // ****************************************
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      st_q <= tfx_pkg::S_FETCH;
      op_q <= 8'h00;
      opnd_q <= 16'h0000;
      nop_q <= 2'h0;
      k_q <= 2'h0;
      ea_q <= 16'h0000;
      dat_q <= 16'h0000;
      icyc_q <= 5'h0;
      acc_q <= 16'h0000;
      tmp_q <= 16'h0000;
      ix_q <= 16'h0000;
      ep_q <= 16'h0000;
      sp_q <= `TFX_SP_RESET;
      pc_q <= `TFX_PC_RESET;
      ps_q <= `TFX_PS_RESET;
      mem_q <= '{rd: 1'b1, wr: 1'b0, fetch: 1'b1, addr: `TFX_PC_RESET, wdata: 8'h00};
      oth_q <= '0;
    end else begin
      st_q <= st_d;
      op_q <= op_d;
      opnd_q <= opnd_d;
      nop_q <= nop_d;
      k_q <= k_d;
      ea_q <= ea_d;
      dat_q <= dat_d;
      icyc_q <= icyc_d;
      acc_q <= acc_d;
      tmp_q <= tmp_d;
      ix_q <= ix_d;
      ep_q <= ep_d;
      sp_q <= sp_d;
      pc_q <= pc_d;
      ps_q <= ps_d;
      mem_q <= mem_d;
      oth_q <= oth_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  assign mem_req = mem_q;
  assign other_req = oth_q;
  assign arch = '{acc: acc_q, tmp: tmp_q, ix: ix_q, ep: ep_q, sp: sp_q, pc: pc_q, ps: ps_q};
endmodule : tfx_xfer_core

//--- tfx_xfer_core_asserts.sv
`timescale 1ns/1ns
module tfx_xfer_core_asserts (
  input wire logic clock,
  input wire logic arst_n,
  input wire tfx_pkg::tfx_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  input wire tfx_pkg::tfx_other_req_t other_req,
  input wire tfx_pkg::tfx_other_ret_t other_ret,
  input wire tfx_pkg::tfx_arch_t arch
);
  // ***
  // cycle phase helper
  // ***
  logic [1:0] ph_q;
  logic [1:0] ph_d;
  wire logic tk = ph_q == 2'd3;
  // next phase
  always_comb begin
    ph_d = ph_q + 2'd1;
  end
  // phase register
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      ph_q <= 2'd0;
    end else begin
      ph_q <= ph_d;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // opcode taken at a tick
  sequence s_op(logic [7:0] op);
    mem_req.fetch && tk && mem_rdata == op;
  endsequence
  sequence s_set;
    mem_req.fetch && tk && mem_rdata[7:3] == 5'h15;
  endsequence
  a_req_stands: assert property (ph_q != 2'd0 |-> $stable(mem_req) && $stable(arch))
    else $error("request moved inside a cycle");
  a_imm_load: assert property (s_op(8'h04) |=> mem_req.rd && !mem_req.fetch ##4 mem_req.fetch)
    else $error("immediate load timing wrong");
  a_imm_tmp: assert property (s_op(8'h04) ##4 1'b1 |=> arch.acc[7:0] == $past(mem_rdata)
    && arch.tmp[7:0] == $past(arch.acc[7:0]) && $stable(arch.tmp[15:8]))
    else $error("byte load copy wrong");
  a_swap_bytes: assert property (s_op(8'h10) |=>
    arch.acc == {$past(arch.acc[7:0]), $past(arch.acc[15:8])} && !mem_req.fetch ##4 mem_req.fetch)
    else $error("swap wrong");
  a_xch_low: assert property (s_op(8'h42) |=> arch.acc[7:0] == $past(arch.tmp[7:0])
    && arch.tmp[7:0] == $past(arch.acc[7:0]) && $stable(arch.acc[15:8]) && $stable(arch.tmp[15:8]))
    else $error("byte exchange wrong");
  a_word_store: assert property (s_op(8'hd5) ##4 1'b1 |=> mem_req.wr && mem_req.addr[15:8] == 8'h00
    && mem_req.wdata == arch.acc[15:8] ##4 mem_req.wr && mem_req.wdata == arch.acc[7:0]
    && mem_req.addr == $past(mem_req.addr, 4) + 16'h1)
    else $error("word store order wrong");
  a_bit_set: assert property (s_set |=> ##8 mem_req.wr && mem_req.addr == {8'h00, $past(mem_rdata, 5)}
    && mem_req.wdata == ($past(mem_rdata) | (8'h01 << $past(mem_rdata[2:0], 9))))
    else $error("bit set wrong");
  a_other_idle: assert property (other_req.valid |-> !mem_req.rd && !mem_req.wr
    && other_req.vct == other_req.opcode[2:0])
    else $error("hand-off not idle");
  a_other_done: assert property (other_req.valid && other_ret.done && tk |=> !other_req.valid
    && mem_req.fetch && mem_req.addr == $past(other_ret.next_pc))
    else $error("resume wrong");
endmodule : tfx_xfer_core_asserts
bind tfx_xfer_core tfx_xfer_core_asserts u_chk (.clock(clock), .arst_n(arst_n), .mem_req(mem_req),
  .mem_rdata(mem_rdata), .other_req(other_req), .other_ret(other_ret), .arch(arch));

//--- tfx_mem_model.sv
`timescale 1ns/1ns
module tfx_mem_model (
  input wire logic clock,
  input wire tfx_pkg::tfx_mem_req_t mem_req,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:65535];
  logic [7:0] last_q = 8'h00;
  // clear store before the bench loads it
  initial begin
    for (int i = 0; i < 65536; i++) m[i] = 8'h00;
  end
  // answer at once, idle bus toggles
  always_comb begin
    mem_rdata = mem_req.rd ? m[mem_req.addr] : ~last_q;
  end
  // write while request stands
  always @(posedge clock) begin
    if (mem_req.wr) m[mem_req.addr] <= mem_req.wdata;
    last_q <= mem_rdata;
  end
endmodule : tfx_mem_model

//--- tfx_xfer_core_tb.sv
`timescale 1ns/1ns
module tfx_xfer_core_tb;
  logic clock;
  logic arst_n;
  tfx_pkg::tfx_mem_req_t mem_req;
  logic [7:0] mem_rdata;
  tfx_pkg::tfx_other_req_t other_req;
  tfx_pkg::tfx_other_ret_t other_ret;
  tfx_pkg::tfx_arch_t arch;
  int error_cnt;
  int n_checks;
  int seed;
  int n;
  int acc;
  int tmp;
  int pw;
  int em [int];
  logic [7:0] r, p, q;
  logic [2:0] b, c;
  logic [7:0] prog [$];
  tfx_xfer_core u_tfx_xfer_core (.clock(clock), .arst_n(arst_n), .mem_req(mem_req),
    .mem_rdata(mem_rdata), .other_req(other_req), .other_ret(other_ret), .arch(arch));
  tfx_mem_model u_tfx_mem_model (.clock(clock), .mem_req(mem_req), .mem_rdata(mem_rdata));
  // clock
  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  // outside group answers the first hand-off only
  always @(posedge clock) begin
    other_ret <= '{done: other_req.valid && other_req.pc == 16'h000e, next_pc: 16'h0020};
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ld(input int v);
    tmp = (tmp & 'hff00) | (acc & 'hff);
    acc = (acc & 'hff00) | v;
  endtask : ld
  task automatic wait_other(input logic [15:0] pc_w);
    n = 0;
    while (!(other_req.valid === 1'b1 && other_req.pc === pc_w) && n < 2000) begin
      @(posedge clock);
      #1;
      n++;
    end
    if (n >= 2000) error_cnt++;
  endtask : wait_other
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // watchdog
  initial begin
    #30000;
    error_cnt++;
    end_of_test();
  end
  // main sequence
  initial begin
    arst_n = 1'b0;
    error_cnt = 0;
    n_checks = 0;
    seed = 32'h19ea;
    r = $random(seed);
    p = $random(seed);
    q = $random(seed);
    b = $random(seed);
    c = $random(seed);
    // operands follow opcode in program order
    prog = '{8'h04, 8'ha5, 8'h10, 8'h04, r, 8'hd5, 8'h40, 8'h42, 8'h83,
      8'ha8 | b, 8'h50, 8'ha0 | c, 8'h51, 8'he0};
    #1;
    foreach (prog[i]) u_tfx_mem_model.m[i] = prog[i];
    u_tfx_mem_model.m[16'h50] = p;
    u_tfx_mem_model.m[16'h51] = q;
    // pointers from the accumulator, then a banked register round trip
    prog = '{8'h04, 8'h00, 8'he1, 8'he2, 8'he3, 8'h8a, q, 8'h0a, 8'he0};
    foreach (prog[i]) u_tfx_mem_model.m[16'h20 + i] = prog[i];
    // reference run
    acc = 0;
    tmp = 0;
    ld('ha5);
    acc = ((acc & 'hff) << 8) | (acc >> 8);
    ld(r);
    em['h40] = acc >> 8;
    em['h41] = acc & 'hff;
    n = acc;
    acc = (acc & 'hff00) | (tmp & 'hff);
    tmp = (tmp & 'hff00) | (n & 'hff);
    em[acc] = tmp >> 8;
    em[acc + 1] = tmp & 'hff;
    em['h50] = p | (8'h01 << b);
    em['h51] = q & ~(8'h01 << c);
    ld(0);
    pw = acc;
    ld(q);
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    wait_other(16'h000e);
    chk("cycles", n, 16'd100);
    wait_other(16'h0029);
    chk("opcode", other_req.opcode, 16'h00e0);
    chk("pc", arch.pc, 16'h0029);
    chk("sp", arch.sp, pw);
    chk("ix", arch.ix, pw);
    chk("ep", arch.ep, pw);
    chk("acc", arch.acc, acc);
    chk("tmp", arch.tmp, tmp);
    chk("status", arch.ps, {12'h000, q[7], q == 8'h00, 2'h0});
    foreach (em[a]) chk("mem", u_tfx_mem_model.m[a], em[a]);
    end_of_test();
  end
endmodule : tfx_xfer_core_tb
